// ---- rtl/bridge_gate_pkg.sv ----
// Shared constants for the bridge gate control and fault logic
package bridge_gate_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ     = 250;          // Block clock rate
    localparam int BOOST_OFF_NS     = 5000;         // Boost off-time after a current trip
    localparam int BOOST_BLANK_NS   = 200;          // Blanking after boost turn-on
    // Cycle counts: off-time is a least time, so it rounds up
    localparam int BOOST_OFF_CYC    = (BOOST_OFF_NS * CLK_FREQ_MHZ + 999) / 1000;
    // Blanking is a longest time, so it rounds down, never below one
    localparam int BOOST_BLANK_CYC  = (BOOST_BLANK_NS * CLK_FREQ_MHZ / 1000 < 1) ? 1 :
                                      BOOST_BLANK_NS * CLK_FREQ_MHZ / 1000;

    // ------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------
    localparam int NUM_PHASES       = 3;            // Bridge phases A, B, C
    localparam int SYNC_STAGES      = 3;            // Synchroniser flops on each pin input, before the filter flop

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RESET_GATE     = 1'h0;         // Gates off during reset
    localparam logic RESET_FAULT_N  = 1'h0;         // Fault shown during reset
    localparam logic RESET_SYNC     = 1'h0;         // Synchroniser contents

endpackage : bridge_gate_pkg

// ---- rtl/pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 1                 // Number of independent bits
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] raw,      // Asynchronous pin levels
    output logic      [WIDTH-1:0] clean     // Filtered, same-domain levels
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (WIDTH < 1)
    begin : g_width_check
        $error("pin_sync WIDTH must be at least one");
    end

    // ------------------------------------------------------------
    // Per-bit synchroniser
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic meta;                         // First stage, read only by second
        logic s2;                           // Second stage
        logic s3;                           // Third stage

        // Shift chain; a floating pin resets to zero so gates stay off
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                meta <= bridge_gate_pkg::RESET_SYNC;
                s2   <= bridge_gate_pkg::RESET_SYNC;
                s3   <= bridge_gate_pkg::RESET_SYNC;
            end
            else
            begin
                meta <= raw[i];
                s2   <= meta;
                s3   <= s2;
            end
        end

        // Accept a change only once the second and third stages agree
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                clean[i] <= bridge_gate_pkg::RESET_SYNC;
            else if (s2 == s3)
                clean[i] <= s3;
        end
    end

endmodule : pin_sync

// ---- rtl/boost_timer.sv ----
// Boost switch on/off control with fixed off-time and blanking
`timescale 1ns/1ps

module boost_timer #(
    parameter int OFF_CYC   = bridge_gate_pkg::BOOST_OFF_CYC,   // Off-time in cycles
    parameter int BLANK_CYC = bridge_gate_pkg::BOOST_BLANK_CYC  // Blanking in cycles
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,          // Boost allowed (no shutdown)
    input  wire logic rail_high,    // Boost rail above regulation point
    input  wire logic current_trip, // Sense resistor voltage above limit
    output logic      switch_on     // Boost switch command
);

    localparam int CW = $clog2((OFF_CYC > BLANK_CYC ? OFF_CYC : BLANK_CYC) + 1);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (OFF_CYC < 1 || BLANK_CYC < 1 || BLANK_CYC >= OFF_CYC)
    begin : g_param_check
        $error("boost_timer needs 1 <= BLANK_CYC < OFF_CYC");
    end

    typedef enum logic [1:0] {IDLE, BLANK, ON, OFF} boost_state_type;

    boost_state_type state;         // Converter phase
    logic [CW-1:0]   count;         // Cycles left in BLANK or OFF

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Shutdown and rail inhibit take priority over any timing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= IDLE;
            count <= '0;
        end
        else if (!run || rail_high)
        begin
            state <= IDLE;
            count <= '0;
        end
        else
        begin
            unique case (state)
                IDLE:
                begin
                    state <= BLANK;
                    count <= CW'(BLANK_CYC - 1);
                end
                BLANK:
                begin
                    // Trip ignored here: recovery spike must not turn it off
                    if (count == '0)
                        state <= ON;
                    else
                        count <= count - 1'b1;
                end
                ON:
                begin
                    if (current_trip)
                    begin
                        state <= OFF;
                        count <= CW'(OFF_CYC - 1);
                    end
                end
                OFF:
                begin
                    if (count == '0)
                    begin
                        state <= BLANK;
                        count <= CW'(BLANK_CYC - 1);
                    end
                    else
                        count <= count - 1'b1;
                end
            endcase
        end
    end

    // Registered switch drive: on during blanking and conduction
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            switch_on <= 1'b0;
        else
            switch_on <= run && !rail_high &&
                         (state == BLANK || (state == ON && !current_trip) ||
                          (state == OFF && count == '0) || state == IDLE);
    end

endmodule : boost_timer

// ---- rtl/bridge_gate_ctrl_fault_logic.sv ----
// Gate command mapping, fault reporting and shutdown for a three-phase bridge
`timescale 1ns/1ps

module bridge_gate_ctrl_fault_logic #(
    parameter int OFF_CYC   = bridge_gate_pkg::BOOST_OFF_CYC,   // Boost off-time cycles
    parameter int BLANK_CYC = bridge_gate_pkg::BOOST_BLANK_CYC  // Boost blanking cycles
) (
    input  wire logic REF_CLK,
    input  wire logic RST_N,
    // Gate commands from the controller
    input  wire logic ENABLE,
    input  wire logic PHASE_A_HIGH_CMD,
    input  wire logic PHASE_B_HIGH_CMD,
    input  wire logic PHASE_C_HIGH_CMD,
    input  wire logic PHASE_A_LOW_CMD,
    input  wire logic PHASE_B_LOW_CMD,
    input  wire logic PHASE_C_LOW_CMD,
    // Comparator results from the analog front end
    input  wire logic HIGH_DS_TRIP_A,
    input  wire logic HIGH_DS_TRIP_B,
    input  wire logic HIGH_DS_TRIP_C,
    input  wire logic LOW_DS_TRIP_A,
    input  wire logic LOW_DS_TRIP_B,
    input  wire logic LOW_DS_TRIP_C,
    input  wire logic DRAIN_OPEN,
    input  wire logic BATTERY_OVER_TRIP,
    input  wire logic BATTERY_OVER_RECOVERED,
    input  wire logic BATTERY_UNDER_TRIP,
    input  wire logic BATTERY_UNDER_RECOVERED,
    input  wire logic GATE_SUPPLY_UNDER,
    input  wire logic LOGIC_SUPPLY_UNDER,
    input  wire logic THERMAL_TRIP,
    input  wire logic BOOST_CURRENT_TRIP,
    input  wire logic BOOST_RAIL_HIGH,
    // Gate outputs
    output logic      PHASE_A_HIGH_GATE,
    output logic      PHASE_B_HIGH_GATE,
    output logic      PHASE_C_HIGH_GATE,
    output logic      PHASE_A_LOW_GATE,
    output logic      PHASE_B_LOW_GATE,
    output logic      PHASE_C_LOW_GATE,
    // Status outputs
    output logic      FAULT_N,
    output logic      BATTERY_OVER_FLAG,
    output logic      BATTERY_OVER_FLAG_OE,
    output logic      BATTERY_UNDER_FLAG,
    output logic      BATTERY_UNDER_FLAG_OE,
    // Supply control
    output logic      BOOST_SWITCH_ON,
    output logic      GATE_SUPPLY_ON
);

    localparam int NP = bridge_gate_pkg::NUM_PHASES;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    localparam int NIN = 23;                // Total synchronised inputs

    logic [NIN-1:0] raw_in;                 // Pin levels, grouped
    logic [NIN-1:0] sync_in;                // Same levels on REF_CLK

    // Every command and comparator passes the filter first
    assign raw_in = {ENABLE,
                     PHASE_C_HIGH_CMD, PHASE_B_HIGH_CMD, PHASE_A_HIGH_CMD,
                     PHASE_C_LOW_CMD, PHASE_B_LOW_CMD, PHASE_A_LOW_CMD,
                     HIGH_DS_TRIP_C, HIGH_DS_TRIP_B, HIGH_DS_TRIP_A,
                     LOW_DS_TRIP_C, LOW_DS_TRIP_B, LOW_DS_TRIP_A,
                     DRAIN_OPEN, BATTERY_OVER_TRIP, BATTERY_OVER_RECOVERED,
                     BATTERY_UNDER_TRIP, BATTERY_UNDER_RECOVERED,
                     GATE_SUPPLY_UNDER, LOGIC_SUPPLY_UNDER, THERMAL_TRIP,
                     BOOST_CURRENT_TRIP, BOOST_RAIL_HIGH};

    pin_sync #(
        .WIDTH (NIN)
    ) u_sync (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .raw   (raw_in),
        .clean (sync_in)
    );

    // Named views of the synchronised bits
    logic          en;                      // Gate enable
    logic [NP-1:0] hi_cmd;                  // High-side commands
    logic [NP-1:0] lo_cmd;                  // Low-side commands
    logic [NP-1:0] hi_ds;                   // Drain rail to phase above threshold
    logic [NP-1:0] lo_ds;                   // Phase to low-side return above threshold
    logic          drain_open;              // Drain sense pin open
    logic          ov_trip;                 // Battery over comparator
    logic          ov_rec;                  // Battery below over hysteresis point
    logic          uv_trip;                 // Battery under comparator
    logic          uv_rec;                  // Battery above under hysteresis point
    logic          gate_supply_rail_uv;                 // Gate supply undervoltage
    logic          vdd_uv;                  // Logic supply undervoltage
    logic          hot;                     // Thermal shutdown
    logic          boost_trip;              // Boost current limit reached
    logic          boost_high;              // Boost rail above regulation

    assign en         = sync_in[22];
    assign hi_cmd     = sync_in[21:19];
    assign lo_cmd     = sync_in[18:16];
    assign hi_ds      = sync_in[15:13];
    assign lo_ds      = sync_in[12:10];
    assign drain_open = sync_in[9];
    assign ov_trip    = sync_in[8];
    assign ov_rec     = sync_in[7];
    assign uv_trip    = sync_in[6];
    assign uv_rec     = sync_in[5];
    assign gate_supply_rail_uv    = sync_in[4];
    assign vdd_uv     = sync_in[3];
    assign hot        = sync_in[2];
    assign boost_trip = sync_in[1];
    assign boost_high = sync_in[0];

    // ------------------------------------------------------------
    // Battery flags with hysteresis
    // ------------------------------------------------------------
    logic ov_state;                         // Latched overvoltage condition
    logic uv_state;                         // Latched undervoltage condition

    // Set on trip, clear only once recovery is seen; trip wins
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            ov_state <= 1'b0;
        else if (ov_trip)
            ov_state <= 1'b1;
        else if (ov_rec)
            ov_state <= 1'b0;
    end

    // Same scheme for undervoltage
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            uv_state <= 1'b0;
        else if (uv_trip)
            uv_state <= 1'b1;
        else if (uv_rec)
            uv_state <= 1'b0;
    end

    // ------------------------------------------------------------
    // Protective shutdown
    // ------------------------------------------------------------
    logic shutdown;                         // Gates, boost and regulator off
    logic flags_float;                      // Both flags released

    // Undervoltage uses the latched state so hysteresis applies
    assign shutdown    = hot || vdd_uv || uv_state;
    assign flags_float = hot || vdd_uv;

    // ------------------------------------------------------------
    // Gate mapping
    // ------------------------------------------------------------
    logic [NP-1:0] next_hi_gate;            // Gate values for next edge
    logic [NP-1:0] next_lo_gate;
    logic [NP-1:0] hi_gate;                 // Registered gate drive
    logic [NP-1:0] lo_gate;

    // Faults from the drain-source monitor never appear here
    for (genvar p = 0; p < NP; p++)
    begin : g_phase
        // Both commands high gives both off, so no shoot-through
        assign next_hi_gate[p] = en && !shutdown && hi_cmd[p] && !lo_cmd[p];
        assign next_lo_gate[p] = en && !shutdown && lo_cmd[p] && !hi_cmd[p];
    end

    // Gate registers; reset holds every transistor off
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            hi_gate <= {NP{bridge_gate_pkg::RESET_GATE}};
            lo_gate <= {NP{bridge_gate_pkg::RESET_GATE}};
        end
        else
        begin
            hi_gate <= next_hi_gate;
            lo_gate <= next_lo_gate;
        end
    end

    assign PHASE_A_HIGH_GATE = hi_gate[0];
    assign PHASE_B_HIGH_GATE = hi_gate[1];
    assign PHASE_C_HIGH_GATE = hi_gate[2];
    assign PHASE_A_LOW_GATE  = lo_gate[0];
    assign PHASE_B_LOW_GATE  = lo_gate[1];
    assign PHASE_C_LOW_GATE  = lo_gate[2];

    // ------------------------------------------------------------
    // Motor lead faults
    // ------------------------------------------------------------
    logic lead_fault;                       // Any short or open bridge

    // Compare against the gate actually on, so disabled phases stay quiet.
    // Open drain sense looks like short-to-ground on every high side.
    assign lead_fault = |(hi_gate & (hi_ds | {NP{drain_open}}))
                      | |(lo_gate & lo_ds);

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    // Fault is a live level; the controller does its own filtering
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            FAULT_N <= bridge_gate_pkg::RESET_FAULT_N;
        else
            FAULT_N <= !(lead_fault || ov_state || uv_state || gate_supply_rail_uv ||
                         vdd_uv || hot);
    end

    // Under wins over over, so both never read high together
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            BATTERY_OVER_FLAG     <= 1'b0;
            BATTERY_UNDER_FLAG    <= 1'b0;
            BATTERY_OVER_FLAG_OE  <= 1'b0;
            BATTERY_UNDER_FLAG_OE <= 1'b0;
        end
        else
        begin
            BATTERY_OVER_FLAG     <= ov_state && !uv_state && !flags_float;
            BATTERY_UNDER_FLAG    <= uv_state && !flags_float;
            BATTERY_OVER_FLAG_OE  <= !flags_float;
            BATTERY_UNDER_FLAG_OE <= !flags_float;
        end
    end

    // ------------------------------------------------------------
    // Supplies
    // ------------------------------------------------------------
    // Regulator restarts only when the shutdown cause has cleared
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            GATE_SUPPLY_ON <= 1'b0;
        else
            GATE_SUPPLY_ON <= !shutdown;
    end

    // Boost timing lives in its own module; output already registered
    boost_timer #(
        .OFF_CYC   (OFF_CYC),
        .BLANK_CYC (BLANK_CYC)
    ) u_boost (
        .clk          (REF_CLK),
        .rst_n        (RST_N),
        .run          (!shutdown),
        .rail_high    (boost_high),
        .current_trip (boost_trip),
        .switch_on    (BOOST_SWITCH_ON)
    );

endmodule : bridge_gate_ctrl_fault_logic

// ---- tb/bridge_gate_checker_assertions.sv ----
// Port-level assertions for the bridge gate control block
`timescale 1ns/1ps

module bridge_gate_checker #(
    parameter int OFF_CYC   = 20,   // Boost off-time cycles
    parameter int BLANK_CYC = 4     // Boost blanking cycles
) (
    input wire logic REF_CLK, RST_N, ENABLE, PHASE_A_HIGH_CMD, PHASE_A_LOW_CMD,
    input wire logic GATE_SUPPLY_UNDER, LOGIC_SUPPLY_UNDER, THERMAL_TRIP, BOOST_RAIL_HIGH,
    input wire logic BATTERY_UNDER_TRIP, BATTERY_UNDER_RECOVERED, FAULT_N,
    input wire logic BOOST_SWITCH_ON, GATE_SUPPLY_ON,
    input wire logic PHASE_A_HIGH_GATE, PHASE_B_HIGH_GATE, PHASE_C_HIGH_GATE,
    input wire logic PHASE_A_LOW_GATE, PHASE_B_LOW_GATE, PHASE_C_LOW_GATE,
    input wire logic BATTERY_OVER_FLAG, BATTERY_UNDER_FLAG,
    input wire logic BATTERY_OVER_FLAG_OE, BATTERY_UNDER_FLAG_OE
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // Eight cycles cover the worst pin-to-output latency of six edges
    wire [5:0] gates = {PHASE_A_HIGH_GATE, PHASE_B_HIGH_GATE, PHASE_C_HIGH_GATE,
                        PHASE_A_LOW_GATE, PHASE_B_LOW_GATE, PHASE_C_LOW_GATE};
    wire       down  = THERMAL_TRIP || LOGIC_SUPPLY_UNDER;  // Flag-floating shutdown

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_no_shoot_through: assert property ((gates[5:3] & gates[2:0]) == 3'h0)
        else $error("both gates of one phase on");
    a_coast_gates_off: assert property (!ENABLE [*8] |-> gates == 6'h00)
        else $error("gate on while disabled");
    a_high_cmd_follows: assert property ((ENABLE && PHASE_A_HIGH_CMD && !PHASE_A_LOW_CMD
        && !down && !BATTERY_UNDER_TRIP && BATTERY_UNDER_RECOVERED) [*8] |-> PHASE_A_HIGH_GATE)
        else $error("commanded high gate stays off");
    a_shutdown_all_off: assert property (down [*8] |-> gates == 6'h00
        && !BOOST_SWITCH_ON && !GATE_SUPPLY_ON)
        else $error("drive left on in shutdown");
    a_flags_float: assert property (down [*8] |-> !BATTERY_OVER_FLAG_OE
        && !BATTERY_UNDER_FLAG_OE)
        else $error("flags driven in shutdown");
    a_flags_exclusive: assert property (!(BATTERY_OVER_FLAG && BATTERY_UNDER_FLAG))
        else $error("both battery flags high");
    a_supply_fault: assert property (GATE_SUPPLY_UNDER [*8] |-> !FAULT_N)
        else $error("supply fault not reported");
    a_rail_holds_off: assert property (BOOST_RAIL_HIGH [*8] |-> !BOOST_SWITCH_ON)
        else $error("boost on with rail high");
    a_boost_off_time: assert property ($fell(BOOST_SWITCH_ON) && !BOOST_RAIL_HIGH
        && !down && !BATTERY_UNDER_TRIP |-> !BOOST_SWITCH_ON [*8])
        else $error("boost off-time cut short");
    a_boost_blanking: assert property ($rose(BOOST_SWITCH_ON) && !BOOST_RAIL_HIGH
        && !down |-> BOOST_SWITCH_ON [*3])
        else $error("boost off within blanking");
endmodule : bridge_gate_checker

bind bridge_gate_ctrl_fault_logic bridge_gate_checker #(.OFF_CYC(OFF_CYC),
    .BLANK_CYC(BLANK_CYC)) bridge_gate_checker_i (.*);

// ---- tb/motor_ctrl_model.sv ----
// Behavioural model of the motor controller driving commands and reading faults
`timescale 1ns/1ps

module motor_ctrl_model (
    input  wire logic       clk,
    input  wire logic [6:0] want,           // {enable, high A..C, low A..C}
    input  wire logic       FAULT_N,
    input  wire logic       BATTERY_OVER_FLAG_OE,
    input  wire logic       BATTERY_UNDER_FLAG_OE,
    output logic            ENABLE, PHASE_A_HIGH_CMD, PHASE_B_HIGH_CMD, PHASE_C_HIGH_CMD,
    output logic            PHASE_A_LOW_CMD, PHASE_B_LOW_CMD, PHASE_C_LOW_CMD,
    output logic            flags_float,    // Both flags released: shutdown seen
    output logic            fault_real      // Fault held long enough to trust
);
    logic [1:0] low_run = 2'h0;             // Cycles of fault seen low

    // Commands leave on a clock edge, enable and phases together
    always_ff @(posedge clk)
    begin
        {ENABLE, PHASE_A_HIGH_CMD, PHASE_B_HIGH_CMD, PHASE_C_HIGH_CMD,
         PHASE_A_LOW_CMD, PHASE_B_LOW_CMD, PHASE_C_LOW_CMD} <= want;
    end

    // Switching glitches are short, so only a lasting fault is believed
    always_ff @(posedge clk)
    begin
        low_run <= FAULT_N ? 2'h0 : low_run + {1'h0, low_run != 2'h3};
    end

    assign fault_real  = low_run == 2'h3;
    assign flags_float = !BATTERY_OVER_FLAG_OE && !BATTERY_UNDER_FLAG_OE;
endmodule : motor_ctrl_model

// ---- tb/tb.sv ----
// Self-checking testbench for the bridge gate control block
`timescale 1ns/1ps

module tb;
    localparam int         OFF  = 20;       // Shortened boost off-time
    localparam logic [15:0] hs_a = 16'h0001, ls_a = 16'h0008, dopen = 16'h0040;
    localparam logic [15:0] ov_t = 16'h0080, ov_r = 16'h0100, uv_t = 16'h0200;
    localparam logic [15:0] uv_r = 16'h0400, gs_uv = 16'h0800, ls_uv = 16'h1000;
    localparam logic [15:0] hot = 16'h2000, cur = 16'h4000, rail = 16'h8000;
    localparam logic [15:0] norm = 16'h0500; // Battery in range, nothing tripped
    logic REF_CLK, RST_N, ENABLE, PHASE_A_HIGH_CMD, PHASE_B_HIGH_CMD, PHASE_C_HIGH_CMD;
    logic PHASE_A_LOW_CMD, PHASE_B_LOW_CMD, PHASE_C_LOW_CMD, flags_float, fault_real;
    logic PHASE_A_HIGH_GATE, PHASE_B_HIGH_GATE, PHASE_C_HIGH_GATE, PHASE_A_LOW_GATE;
    logic PHASE_B_LOW_GATE, PHASE_C_LOW_GATE, FAULT_N, BATTERY_OVER_FLAG, BATTERY_UNDER_FLAG;
    logic BATTERY_OVER_FLAG_OE, BATTERY_UNDER_FLAG_OE, BOOST_SWITCH_ON, GATE_SUPPLY_ON;
    wire  HIGH_DS_TRIP_A, HIGH_DS_TRIP_B, HIGH_DS_TRIP_C, LOW_DS_TRIP_A, LOW_DS_TRIP_B;
    wire  LOW_DS_TRIP_C, DRAIN_OPEN, BATTERY_OVER_TRIP, BATTERY_OVER_RECOVERED;
    wire  BATTERY_UNDER_TRIP, BATTERY_UNDER_RECOVERED, GATE_SUPPLY_UNDER, LOGIC_SUPPLY_UNDER;
    wire  THERMAL_TRIP, BOOST_CURRENT_TRIP, BOOST_RAIL_HIGH;
    logic [15:0] cmp;                       // All comparator pins in one word
    logic [6:0]  want;                      // Command word for the controller model
    logic [5:0]  eg;                        // Expected gates
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          n;
    wire  [5:0]  gates = {PHASE_A_HIGH_GATE, PHASE_B_HIGH_GATE, PHASE_C_HIGH_GATE,
                          PHASE_A_LOW_GATE, PHASE_B_LOW_GATE, PHASE_C_LOW_GATE};

    assign {BOOST_RAIL_HIGH, BOOST_CURRENT_TRIP, THERMAL_TRIP, LOGIC_SUPPLY_UNDER,
            GATE_SUPPLY_UNDER, BATTERY_UNDER_RECOVERED, BATTERY_UNDER_TRIP,
            BATTERY_OVER_RECOVERED, BATTERY_OVER_TRIP, DRAIN_OPEN, LOW_DS_TRIP_C,
            LOW_DS_TRIP_B, LOW_DS_TRIP_A, HIGH_DS_TRIP_C, HIGH_DS_TRIP_B,
            HIGH_DS_TRIP_A} = cmp;

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    bridge_gate_ctrl_fault_logic #(.OFF_CYC(OFF), .BLANK_CYC(4))
        bridge_gate_ctrl_fault_logic_i (.*);
    motor_ctrl_model motor_ctrl_model_i (.clk(REF_CLK), .*);

    // Clock at 250 MHz
    initial
    begin
        REF_CLK = 1'h0;
        forever #2 REF_CLK = ~REF_CLK;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Eight cycles exceed the pin-to-output latency plus the model's own flop
    task automatic drive(input logic [6:0] w);
        @(posedge REF_CLK);
        want <= w;
        repeat (8) @(posedge REF_CLK);
    endtask : drive

    task automatic apply(input logic [15:0] c);
        @(posedge REF_CLK);
        cmp <= c;
        repeat (9) @(posedge REF_CLK);
    endtask : apply

    // Bounded wait for the boost switch, reading the level settled before each edge
    task automatic wait_boost(input logic v);
        int i;
        for (i = 0; i < 200; i++)
        begin
            @(posedge REF_CLK);
            if (BOOST_SWITCH_ON === v)
                break;
        end
        if (i == 200)
        begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : wait_boost

    task automatic report_and_stop;
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        RST_N = 1'h0;
        want  = 7'h00;
        cmp   = norm;
        repeat (4) @(posedge REF_CLK);
        RST_N <= 1'h1;
        // Every enable and command combination
        for (int w = 0; w < 128; w++)
        begin
            drive(w[6:0]);
            eg = w[6] ? {w[5:3] & ~w[2:0], w[2:0] & ~w[5:3]} : 6'h00;
            check(gates, eg);
        end
        // Lead faults only on transistors commanded on
        drive(7'h60);
        apply(norm | hs_a);
        check({FAULT_N, gates}, {1'h0, 6'h20});
        apply(norm | (hs_a << 1));
        check(FAULT_N, 1'h1);
        apply(norm | ls_a);
        check(FAULT_N, 1'h1);
        apply(norm | dopen);
        check({fault_real, FAULT_N, gates}, {2'h2, 6'h20});
        drive(7'h20);
        check(FAULT_N, 1'h1);
        drive(7'h44);
        apply(norm | ls_a);
        check({FAULT_N, gates}, {1'h0, 6'h04});
        apply(norm);
        drive(7'h60);
        // Overvoltage flag holds until recovered
        apply(ov_t | uv_r);
        check({FAULT_N, BATTERY_OVER_FLAG, BATTERY_UNDER_FLAG}, 3'h2);
        apply(uv_r);
        check({FAULT_N, BATTERY_OVER_FLAG, BATTERY_UNDER_FLAG}, 3'h2);
        apply(norm);
        check({FAULT_N, BATTERY_OVER_FLAG, BATTERY_UNDER_FLAG}, 3'h4);
        // Undervoltage flag holds and shuts the drive down
        apply(uv_t | ov_r);
        check({FAULT_N, BATTERY_UNDER_FLAG, GATE_SUPPLY_ON, gates}, 9'h080);
        apply(ov_r);
        check({FAULT_N, BATTERY_UNDER_FLAG, GATE_SUPPLY_ON, gates}, 9'h080);
        apply(norm);
        check({FAULT_N, BATTERY_UNDER_FLAG, GATE_SUPPLY_ON, gates}, 9'h160);
        apply(ov_t | uv_t);
        check({BATTERY_OVER_FLAG, BATTERY_UNDER_FLAG}, 2'h1);
        // Thermal and logic supply faults release both flags
        for (int k = 0; k < 2; k++)
        begin
            apply(norm | (k == 0 ? hot : ls_uv));
            check({BATTERY_OVER_FLAG_OE, BATTERY_UNDER_FLAG_OE, flags_float, FAULT_N,
                   GATE_SUPPLY_ON, BOOST_SWITCH_ON}, 6'h08);
            check(gates, 6'h00);
            apply(norm);
            check({BATTERY_OVER_FLAG_OE, BATTERY_UNDER_FLAG_OE, gates}, 8'hE0);
        end
        apply(norm | gs_uv);
        check({FAULT_N, gates}, {1'h0, 6'h20});
        // Boost held off by the rail, then a current trip and its off-time
        apply(norm | rail);
        check(BOOST_SWITCH_ON, 1'h0);
        cmp <= norm;
        wait_boost(1'h1);
        cmp <= norm | cur;
        wait_boost(1'h0);
        cmp <= norm;
        n = 0;
        while (BOOST_SWITCH_ON !== 1'h1 && n < 200)
        begin
            @(posedge REF_CLK);
            n++;
        end
        check(n[7:0], OFF[7:0]);
        report_and_stop();
    end
endmodule : tb
